// ---- rtl/serial_config_flash_loader_pkg.sv ----
package serial_config_flash_loader_pkg;

  // clock rates in MHz
  localparam int SYS_CLK_MHZ      = 50;
  localparam int OSC_FAST_MHZ     = 40;
  localparam int OSC_SLOW_MHZ     = 20;
  localparam int USER_CLK_MAX_MHZ = 40;

  // sampled pins take two cycles to reach logic, so a serial clock phase
  // shorter than this would sample flash data from before the last edge
  localparam int EDGE_GAP_MIN = 3;

  // half period of the serial clock, rounded down, floored by the gap
  localparam int HALF_FAST_RAW = SYS_CLK_MHZ / (2 * OSC_FAST_MHZ);
  localparam int HALF_SLOW_RAW = SYS_CLK_MHZ / (2 * OSC_SLOW_MHZ);
  localparam int HALF_FAST_CYC = (HALF_FAST_RAW < EDGE_GAP_MIN) ?
                                 EDGE_GAP_MIN : HALF_FAST_RAW;
  localparam int HALF_SLOW_CYC = (HALF_SLOW_RAW < EDGE_GAP_MIN) ?
                                 EDGE_GAP_MIN : HALF_SLOW_RAW;
  localparam int DIV_W         = 4;

  // read command frame: opcode then start address, msb first
  localparam int              BYTE_W       = 8;
  localparam int              ADDR_W       = 24;
  localparam int              CMD_BITS     = BYTE_W + ADDR_W;
  localparam logic [7:0]      READ_OPCODE  = 8'h03;
  localparam logic [7:0]      ZERO_BYTE    = 8'h00;
  localparam int              BUF_DEPTH    = 2;

  typedef enum logic [1:0] {
    active_serial_mode,
    parallel_self_load_mode,
    host_driven_parallel_mode
  } config_mode_e;

  typedef enum logic [2:0] {
    st_idle,
    st_select,
    st_command,
    st_data,
    st_forward,
    st_loaded
  } load_state_e;

  // pins sampled into the system clock domain
  typedef struct packed {
    logic         config_request_n;
    logic         device_enable_n;
    logic         external_user_clock;
    logic         flash_data_in;
    logic         flash_command_in;
    logic         osc_slow_select;
    logic         use_user_clock;
    logic         compressed_stream;
    logic         chain_forward;
    config_mode_e mode;
  } pin_in_s;

  // flash-side pin group, used for both levels and enables
  typedef struct packed {
    logic clk;
    logic select_n;
    logic command;
  } flash_pins_s;

endpackage : serial_config_flash_loader_pkg

// ---- rtl/serial_config_flash_loader.sv ----
// Functional notes
// - base variant: serial clock from 40 MHz oscillator
// - transceiver: 20/40 MHz oscillator or user clock
// - one bitstream bit per serial clock period
// - enable input high: release the flash interface
// - request input low holds loader in reset
// - select pin doubles as parallel flash enable
// - command pin doubles as parallel data bit 1
// - compressed bitstream expanded internally
// - chain enable high loading, then forward copy
`timescale 1ns/10ps
module serial_config_flash_loader
  import serial_config_flash_loader_pkg::*;
#(
  parameter bit                TRANSCEIVER_VARIANT = 1'b0,
  parameter int                COUNT_W             = 24,
  parameter logic [COUNT_W-1:0] BITSTREAM_BYTES    = 24'h000100,
  parameter logic [COUNT_W-1:0] FORWARD_BITS       = 24'h000800,
  parameter logic [ADDR_W-1:0] START_ADDRESS       = 24'h000000
) (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire pin_in_s     pins_in,
  input  wire logic        parallel_flash_enable_n,
  input  wire logic        parallel_data1_out,
  input  wire logic        parallel_data1_drive,
  output logic             parallel_data1_in,
  output flash_pins_s      flash_out,
  output flash_pins_s      flash_oe_n,
  output logic [7:0]       config_byte,
  output logic             config_byte_valid,
  input  wire logic        config_byte_ready,
  output logic             chain_enable_out,
  output logic             downstream_data,
  output logic             downstream_clock,
  output logic             config_done
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  pin_in_s pin_meta;
  pin_in_s pin_sync;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= pins_in;
      pin_sync <= pin_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state

  load_state_e         state, next_state;
  logic                sclk, next_sclk;
  logic [CMD_BITS-1:0] cmd_sr, next_cmd_sr;
  logic [5:0]          bit_cnt, next_bit_cnt;
  logic [DIV_W-1:0]    div_cnt, next_div_cnt;
  logic                user_clk_prev, next_user_clk_prev;
  logic [7:0]          shift_byte, next_shift_byte;
  logic [2:0]          shift_cnt, next_shift_cnt;
  logic                literal, next_literal;
  logic [COUNT_W-1:0]  byte_cnt, next_byte_cnt;
  logic [COUNT_W-1:0]  fwd_cnt, next_fwd_cnt;
  logic                fwd_data, next_fwd_data;
  logic [7:0]          buf_mem [BUF_DEPTH];
  logic [7:0]          next_buf_mem [BUF_DEPTH];
  logic                wr_ptr, next_wr_ptr;
  logic                rd_ptr, next_rd_ptr;
  logic [1:0]          fill, next_fill;
  flash_pins_s         next_flash_out, next_flash_oe_n;
  logic                next_chain_enable_out;
  logic                next_downstream_clock;

  logic                serial_sel, released, active, buf_full;
  logic                tick, tick_osc, user_edge, pop, push;
  logic [DIV_W-1:0]    half_cyc;
  logic [7:0]          push_byte;

  assign buf_full          = (fill == 2'(BUF_DEPTH));
  assign config_byte_valid = (fill != 2'h0);
  assign config_byte       = buf_mem[rd_ptr];
  assign pop               = config_byte_valid && config_byte_ready;
  assign parallel_data1_in = pin_sync.flash_command_in;
  assign downstream_data   = fwd_data;
  assign config_done       = (state == st_loaded);

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb begin
    next_state         = state;
    next_sclk          = sclk;
    next_cmd_sr        = cmd_sr;
    next_bit_cnt       = bit_cnt;
    next_div_cnt       = div_cnt;
    next_shift_byte    = shift_byte;
    next_shift_cnt     = shift_cnt;
    next_literal       = literal;
    next_byte_cnt      = byte_cnt;
    next_fwd_cnt       = fwd_cnt;
    next_fwd_data      = fwd_data;
    next_buf_mem       = buf_mem;
    next_wr_ptr        = wr_ptr;
    next_rd_ptr        = rd_ptr;
    next_user_clk_prev = pin_sync.external_user_clock;
    push               = 1'b0;
    push_byte          = ZERO_BYTE;

    serial_sel = (pin_sync.mode == active_serial_mode);
    // released by enable or held by request
    released   = pin_sync.device_enable_n || !pin_sync.config_request_n;
    active     = (state != st_idle) && (state != st_loaded);

    half_cyc = (TRANSCEIVER_VARIANT && pin_sync.osc_slow_select) ?
               DIV_W'(HALF_SLOW_CYC) : DIV_W'(HALF_FAST_CYC);
    tick_osc  = (div_cnt == half_cyc - DIV_W'(1));
    user_edge = (pin_sync.external_user_clock != user_clk_prev);
    // a full buffer freezes the serial clock so no word is lost
    tick      = !buf_full &&
                ((TRANSCEIVER_VARIANT && pin_sync.use_user_clock) ?
                 user_edge : tick_osc);
    next_div_cnt = (!active || buf_full || tick_osc) ? '0 :
                   div_cnt + DIV_W'(1);

    if (released || !serial_sel) begin
      next_state    = st_idle;
      next_sclk     = 1'b0;
      next_bit_cnt  = '0;
      next_byte_cnt = '0;
      next_fwd_cnt  = '0;
      next_literal  = 1'b0;
      next_shift_cnt = '0;
    end else if (state == st_idle) begin
      // frame the read command and start address
      next_state  = st_select;
      next_cmd_sr = {READ_OPCODE, START_ADDRESS};
    end else if (state == st_select) begin
      // quiet half period with select low, so the flash sees only 32 bits
      next_state = tick ? st_command : st_select;
    end else if (active && tick) begin
      next_sclk = !sclk;
      if (!sclk) begin
        // rising serial edge: flash samples command, we sample data
        unique case (state)
          st_command: next_bit_cnt = bit_cnt + 6'h01;
          st_data: begin
            // one bit per serial clock period
            if (byte_cnt != BITSTREAM_BYTES) begin
              if (pin_sync.compressed_stream && !literal) begin
                if (pin_sync.flash_data_in) begin
                  next_literal   = 1'b1;
                  next_shift_cnt = '0;
                end else begin
                  push = 1'b1;
                end
              end else begin
                next_shift_byte = {shift_byte[6:0], pin_sync.flash_data_in};
                next_shift_cnt  = shift_cnt + 3'h1;
                if (shift_cnt == 3'h7) begin
                  push         = 1'b1;
                  push_byte    = next_shift_byte;
                  next_literal = 1'b0;
                end
              end
            end
          end
          st_forward: begin
            next_fwd_data = pin_sync.flash_data_in;
            next_fwd_cnt  = fwd_cnt + COUNT_W'(1);
          end
          default: ;
        endcase
      end else begin
        // falling serial edge: advance command or finish
        unique case (state)
          st_command: begin
            if (bit_cnt == 6'(CMD_BITS)) begin
              next_state = st_data;
            end else begin
              next_cmd_sr = {cmd_sr[CMD_BITS-2:0], 1'b0};
            end
          end
          st_data: begin
            // hand the next copy downstream when chained
            if (byte_cnt == BITSTREAM_BYTES) begin
              next_state = pin_sync.chain_forward ? st_forward : st_loaded;
            end
          end
          st_forward: begin
            if (fwd_cnt == FORWARD_BITS) begin
              next_state = st_loaded;
            end
          end
          default: ;
        endcase
      end
    end

    if (next_state == st_loaded || next_state == st_idle) begin
      next_sclk = 1'b0;
    end

    if (push) begin
      next_buf_mem[wr_ptr] = push_byte;
      next_wr_ptr          = !wr_ptr;
      next_byte_cnt        = byte_cnt + COUNT_W'(1);
    end
    next_rd_ptr = rd_ptr ^ pop;
    next_fill = fill + 2'(push) - 2'(pop);

    // pin drive; enable low means the pin is driven
    next_flash_out.clk      = next_sclk;
    next_flash_out.select_n = !(next_state inside {st_select, st_command,
                                                   st_data, st_forward});
    next_flash_out.command  = next_cmd_sr[CMD_BITS-1];
    next_flash_oe_n         = '1;
    if (!released) begin
      if (serial_sel) begin
        next_flash_oe_n = '0;
      end else begin
        // select pin as parallel flash enable
        next_flash_out.select_n  = parallel_flash_enable_n;
        next_flash_oe_n.select_n =
          (pin_sync.mode != parallel_self_load_mode);
        // command pin as parallel data bit 1
        next_flash_out.command  = parallel_data1_out;
        next_flash_oe_n.command = !parallel_data1_drive;
      end
    end
    // high while own load runs, low while forwarding and once configured
    next_chain_enable_out = !(next_state inside {st_forward, st_loaded});
    next_downstream_clock = (next_state == st_forward) && next_sclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state            <= st_idle;
      sclk             <= 1'b0;
      cmd_sr           <= '0;
      bit_cnt          <= '0;
      div_cnt          <= '0;
      user_clk_prev    <= 1'b0;
      shift_byte       <= '0;
      shift_cnt        <= '0;
      literal          <= 1'b0;
      byte_cnt         <= '0;
      fwd_cnt          <= '0;
      fwd_data         <= 1'b0;
      buf_mem          <= '{default: ZERO_BYTE};
      wr_ptr           <= 1'b0;
      rd_ptr           <= 1'b0;
      fill             <= '0;
      flash_out        <= '{clk: 1'b0, select_n: 1'b1, command: 1'b0};
      flash_oe_n       <= '1;
      chain_enable_out <= 1'b1;
      downstream_clock <= 1'b0;
    end else begin
      state            <= next_state;
      sclk             <= next_sclk;
      cmd_sr           <= next_cmd_sr;
      bit_cnt          <= next_bit_cnt;
      div_cnt          <= next_div_cnt;
      user_clk_prev    <= next_user_clk_prev;
      shift_byte       <= next_shift_byte;
      shift_cnt        <= next_shift_cnt;
      literal          <= next_literal;
      byte_cnt         <= next_byte_cnt;
      fwd_cnt          <= next_fwd_cnt;
      fwd_data         <= next_fwd_data;
      buf_mem          <= next_buf_mem;
      wr_ptr           <= next_wr_ptr;
      rd_ptr           <= next_rd_ptr;
      fill             <= next_fill;
      flash_out        <= next_flash_out;
      flash_oe_n       <= next_flash_oe_n;
      chain_enable_out <= next_chain_enable_out;
      downstream_clock <= next_downstream_clock;
    end
  end

endmodule : serial_config_flash_loader

// ---- bench/flash_loader_monitor.sv ----
`timescale 1ns/10ps
module flash_loader_monitor
  import serial_config_flash_loader_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire pin_in_s     pins_in,
  input wire flash_pins_s flash_out,
  input wire flash_pins_s flash_oe_n,
  input wire logic [7:0]  config_byte,
  input wire logic        config_byte_valid,
  input wire logic        config_byte_ready,
  input wire logic        chain_enable_out,
  input wire logic        config_done
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
//////////////////////////////////////////////////////////////////////////////
  oe_release_a: assert property (
    pins_in.device_enable_n [*5] |=> flash_oe_n == 3'h7)
    else $error("flash pins driven while disabled");
  request_reset_a: assert property (
    !pins_in.config_request_n [*5] |=> !config_done && flash_oe_n == 3'h7)
    else $error("loader active while request low");
  done_select_a: assert property (
    config_done [*2] |-> flash_out.select_n && !flash_out.clk)
    else $error("flash still selected after load");
  done_chain_a: assert property (
    config_done [*2] |-> !chain_enable_out)
    else $error("chain enable high after load");
  chain_high_a: assert property (
    !flash_out.select_n && !config_done && !pins_in.chain_forward
    |-> chain_enable_out)
    else $error("chain enable low while loading");
  // a short phase would let flash data be sampled stale
  clock_gap_a: assert property (
    $rose(flash_out.clk) && !pins_in.device_enable_n &&
    pins_in.config_request_n |=> flash_out.clk [*2])
    else $error("serial clock high phase too short");
  cmd_stable_a: assert property (
    $changed(flash_out.command) && !flash_out.select_n |-> !flash_out.clk)
    else $error("command changed while clock high");
  hold_byte_a: assert property (
    config_byte_valid && !config_byte_ready
    |=> config_byte_valid && $stable(config_byte))
    else $error("stalled byte lost or changed");
endmodule : flash_loader_monitor

bind serial_config_flash_loader flash_loader_monitor u_flash_loader_monitor (
  .clk_sys(clk_sys), .reset_n(reset_n), .pins_in(pins_in),
  .flash_out(flash_out), .flash_oe_n(flash_oe_n),
  .config_byte(config_byte), .config_byte_valid(config_byte_valid),
  .config_byte_ready(config_byte_ready),
  .chain_enable_out(chain_enable_out), .config_done(config_done)
);

// ---- bench/flash_model.sv ----
`timescale 1ns/10ps
module flash_model (
  input  wire logic        sck,
  input  wire logic        sel_n,
  input  wire logic        cmd,
  input  wire logic [63:0] image,
  output logic             dout = 1'b0,
  output logic [31:0]      cmd_seen = '0
);
  int n_cmd = 0;
  int n_dat = 0;
//////////////////////////////////////////////////////////////////////////////
  // command in on rise
  always @(posedge sck or posedge sel_n) begin
    if (sel_n) begin
      n_cmd <= 0;
    end else if (n_cmd < 32) begin
      cmd_seen <= {cmd_seen[30:0], cmd};
      n_cmd    <= n_cmd + 1;
    end
  end
  // one bit per period
  // released line shows the inverse, never the last bit
  always @(negedge sck or posedge sel_n) begin
    if (sel_n) begin
      n_dat <= 0;
      dout  <= ~dout;
    end else if (n_cmd == 32) begin
      dout  <= image[63 - n_dat];
      n_dat <= n_dat + 1;
    end
  end
endmodule : flash_model

// ---- bench/testbench.sv ----
`timescale 1ns/10ps
module testbench
  import serial_config_flash_loader_pkg::*;
;
  logic        clk_sys;
  logic        reset_n;
  pin_in_s     pins;
  logic        par_en_n;
  logic        d1_out;
  logic        d1_drive;
  logic        rdy;
  flash_pins_s fl_out;
  flash_pins_s fl_oe_n;
  logic [7:0]  cbyte;
  logic        cvalid;
  logic        chain_out;
  logic        done;
  logic [63:0] image;
  logic [31:0] cmd_seen;
  logic        fdata;
  logic        ds_data;
  logic        ds_clk;
  logic [15:0] ds_bits = '0;
  int          bad_count = 0;
  int          n_tests = 0;

  serial_config_flash_loader #(
    .TRANSCEIVER_VARIANT(1'b1),
    .BITSTREAM_BYTES(24'h000004),
    .FORWARD_BITS(24'h000010)
  ) u_serial_config_flash_loader (
    .clk_sys(clk_sys), .reset_n(reset_n), .pins_in(pins),
    .parallel_flash_enable_n(par_en_n), .parallel_data1_out(d1_out),
    .parallel_data1_drive(d1_drive), .parallel_data1_in(),
    .flash_out(fl_out), .flash_oe_n(fl_oe_n), .config_byte(cbyte),
    .config_byte_valid(cvalid), .config_byte_ready(rdy),
    .chain_enable_out(chain_out), .downstream_data(ds_data),
    .downstream_clock(ds_clk), .config_done(done)
  );
  // select pin has a pull-up when released
  flash_model u_flash_model (
    .sck(fl_out.clk), .sel_n(fl_oe_n.select_n | fl_out.select_n),
    .cmd(fl_out.command), .image(image), .dout(fdata),
    .cmd_seen(cmd_seen)
  );
  always @(fdata) pins.flash_data_in = fdata;
  // forwarded bit is steady while the downstream clock is high
  always @(negedge ds_clk) ds_bits = {ds_bits[14:0], ds_data};
//////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic pop_all(input logic [31:0] bytes);
    int k;
    for (int i = 0; i < 4; i++) begin
      k = 0;
      do begin
        @(posedge clk_sys);
        k++;
      end while (cvalid !== 1'b1 && k < 3000);
      check(cbyte, bytes[31 - 8 * i -: 8]);
      rdy <= 1'b1;
      @(posedge clk_sys);
      rdy <= 1'b0;
    end
  endtask : pop_all

  task automatic wait_done();
    int k;
    k = 0;
    while (done !== 1'b1 && k < 3000) begin
      @(posedge clk_sys);
      k++;
    end
    repeat (3) @(posedge clk_sys);
    check(fl_out, 3'h2);
    check(chain_out, 1'b0);
    check(cmd_seen, 32'h03000000);
  endtask : wait_done

  task automatic load_plain();
    repeat (1500) @(posedge clk_sys);
    check(done, 1'b0);
    check(cvalid, 1'b1);
    check(fl_out.select_n, 1'b0);
    check(chain_out, 1'b1);
    pop_all(32'hA53C0F81);
    wait_done();
    check(ds_bits, 16'hC396);
  endtask : load_plain

  task automatic reload_compressed();
    image = {20'h6953C, 44'h0};
    pins.compressed_stream <= 1'b1;
    pins.chain_forward <= 1'b0;
    pins.use_user_clock <= 1'b1;
    pins.config_request_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    check(done, 1'b0);
    check(fl_oe_n, 3'h7);
    pins.config_request_n <= 1'b1;
    repeat (150) @(posedge clk_sys);
    pins.device_enable_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
    check(fl_oe_n, 3'h7);
    pins.config_request_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    pins.device_enable_n <= 1'b0;
    pins.config_request_n <= 1'b1;
    pop_all(32'h00A5003C);
    wait_done();
  endtask : reload_compressed

  task automatic parallel_pins();
    pins.mode <= parallel_self_load_mode;
    pins.config_request_n <= 1'b0;
    par_en_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    pins.config_request_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
    check({fl_oe_n.select_n, fl_out.select_n}, 2'b00);
    par_en_n <= 1'b1;
    d1_drive <= 1'b1;
    d1_out <= 1'b1;
    repeat (6) @(posedge clk_sys);
    check(fl_out.select_n, 1'b1);
    check({fl_oe_n.command, fl_out.command}, 2'b01);
    pins.mode <= host_driven_parallel_mode;
    d1_out <= 1'b0;
    repeat (6) @(posedge clk_sys);
    check({fl_oe_n.command, fl_out.command}, 2'b00);
  endtask : parallel_pins

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
//////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    #7;
    forever #80 pins.external_user_clock = ~pins.external_user_clock;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    wrap_up();
  end
  initial begin
    pins = '0;
    pins.config_request_n = 1'b1;
    pins.mode = active_serial_mode;
    pins.chain_forward = 1'b1;
    image = {32'hA53C0F81, 32'hC3960000};
    par_en_n = 1'b1;
    d1_out = 1'b0;
    d1_drive = 1'b0;
    rdy = 1'b0;
    reset_n = 1'b0;
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    load_plain();
    reload_compressed();
    parallel_pins();
    wrap_up();
  end
endmodule : testbench
